// file: verif/scb_bus_model.sv
// Far side of the bus control pins: terminated lines driven by other devices.
// Assumes the bench asks for a line by raising its bit in line_on_in.
`timescale 1ns/10ps

module scb_bus_model (
  // Lines asserted by other bus devices, active high
  input wire [8:0] line_on_in,
  // Pin levels, active low
  output wire [8:0] line_n_out
);
  // Terminated bus: a released line is pulled up, so it reads inactive
  assign line_n_out = ~line_on_in;
endmodule // scb_bus_model

// file: verif/scb_regs_assertions.sv
// Checker for the configuration/status and interrupt register pair.
// Assumes binding to scb_regs; sees only its ports.
`timescale 1ns/10ps

module scb_regs_assertions (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_in,
  // Processor port
  input wire [4:0] cpu_addr_in,
  input wire [7:0] cpu_wdata_in,
  input wire cpu_wr_in,
  input wire cpu_rd_in,
  input wire [7:0] cpu_rdata_out,
  input wire cpu_irq_out,
  // Arbitration and sequencer
  input wire [7:0] arb_data_out,
  input wire [7:0] arb_data_oe_out,
  input wire seq_connected_in,
  input wire seq_arbitrating_in,
  input wire seq_orderly_point_in,
  input wire async_write_start_in,
  input wire force_connect_out,
  input wire skip_arbitration_out,
  input wire soft_abort_pending_out,
  input wire pipeline_clear_out,
  input wire sequencer_halt_out,
  input wire sm_error_set_out,
  input wire cmd_complete_event_out,
  input wire write_setup_hold_out
);
  wire cfg_wr = cpu_wr_in && cpu_addr_in == 5'h04;
  reg [7:0] cfg_q;
  // Shadow of the last configuration write, for identifier and setup
  always @(posedge ref_clk_in)
    if (rst_in)
      cfg_q <= 8'h00;
    else if (cfg_wr)
      cfg_q <= cpu_wdata_in;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  sequence abort_s;
    (pipeline_clear_out && sm_error_set_out && cmd_complete_event_out) ##1 !pipeline_clear_out;
  endsequence

  hard_abort_a: assert property (
    cfg_wr && cpu_wdata_in[6] |=> sequencer_halt_out ##0 abort_s)
    else $error("hard abort pulses wrong");
  soft_set_a: assert property (
    cfg_wr && cpu_wdata_in[5] && !cpu_wdata_in[6] |=> soft_abort_pending_out)
    else $error("soft abort not pending");
  soft_hold_a: assert property (
    soft_abort_pending_out && !seq_orderly_point_in && !cfg_wr |=> soft_abort_pending_out)
    else $error("soft abort ended early");
  soft_done_a: assert property (
    soft_abort_pending_out && seq_orderly_point_in
    && !(cfg_wr && (cpu_wdata_in[5] || cpu_wdata_in[6]))
    |=> (!soft_abort_pending_out && !sequencer_halt_out) ##0 abort_s)
    else $error("soft abort completion wrong");
  cfg_bits_a: assert property (
    cfg_wr |=> force_connect_out == $past(cpu_wdata_in[7])
    && skip_arbitration_out == $past(cpu_wdata_in[4]))
    else $error("force or skip bit wrong");
  arb_id_a: assert property (
    arb_data_out == 8'h00
    && arb_data_oe_out == (seq_arbitrating_in ? 8'h01 << cfg_q[2:0] : 8'h00))
    else $error("arbitration identifier wrong");
  setup_on_a: assert property (
    async_write_start_in && cfg_q[3] |=> write_setup_hold_out [*2])
    else $error("setup hold too short");
  setup_off_a: assert property (
    async_write_start_in && !cfg_q[3] && !write_setup_hold_out |=> !write_setup_hold_out)
    else $error("setup hold without setup bit");
  conn_rd_a: assert property (
    cpu_rd_in && cpu_addr_in == 5'h04
    |=> cpu_rdata_out[7] == ($past(seq_connected_in) || $past(force_connect_out)))
    else $error("connected bit wrong");
  irq_rst_a: assert property ($fell(rst_in) |-> !cpu_irq_out)
    else $error("irq high after reset");
  mask_off_a: assert property (
    cpu_wr_in && cpu_addr_in == 5'h05 && cpu_wdata_in == 8'h00 |=> !cpu_irq_out)
    else $error("irq with all masked");
endmodule // scb_regs_assertions

// file: verif/tb_scb_regs.sv
// Self-checking bench for scb_regs with a terminated bus pin model.
// Assumes a 250 MHz clock and synchronous active-high reset.
`timescale 1ns/10ps

module tb_scb_regs;
  logic ref_clk_in, rst_in, cpu_wr_in, cpu_rd_in, seq_connected_in, seq_initiator_in;
  logic seq_arbitrating_in, seq_cmd_done_in, seq_cmd_int_req_in, seq_abnormal_in;
  logic seq_orderly_point_in, seq_selected_in, sel_response_en_in, async_write_start_in;
  logic fifo_half_access_in, parity_error_in, overrun_in;
  logic [4:0] cpu_addr_in;
  logic [7:0] cpu_wdata_in, q;
  logic [8:0] lines;
  wire [8:0] pins_n;
  wire [7:0] cpu_rdata_out, arb_data_out, arb_data_oe_out;
  wire cpu_irq_out, force_connect_out, skip_arbitration_out, soft_abort_pending_out;
  wire pipeline_clear_out, sequencer_halt_out, sm_error_set_out, cmd_complete_event_out;
  wire write_setup_hold_out, bus_sel_n_in, bus_bsy_n_in, bus_ack_n_in, bus_req_n_in;
  wire bus_msg_n_in, bus_cd_n_in, bus_io_n_in, bus_atn_n_in, bus_rst_n_in;
  int err_count, samples_checked, cycles;

  assign {bus_rst_n_in, bus_atn_n_in, bus_sel_n_in, bus_bsy_n_in, bus_ack_n_in,
    bus_req_n_in, bus_msg_n_in, bus_cd_n_in, bus_io_n_in} = pins_n;
  scb_bus_model bus_u (.line_on_in(lines), .line_n_out(pins_n));
  scb_regs dut_u (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .cpu_addr_in(cpu_addr_in),
    .cpu_wdata_in(cpu_wdata_in), .cpu_wr_in(cpu_wr_in), .cpu_rd_in(cpu_rd_in),
    .cpu_rdata_out(cpu_rdata_out), .cpu_irq_out(cpu_irq_out), .bus_sel_n_in(bus_sel_n_in),
    .bus_bsy_n_in(bus_bsy_n_in), .bus_ack_n_in(bus_ack_n_in), .bus_req_n_in(bus_req_n_in),
    .bus_msg_n_in(bus_msg_n_in), .bus_cd_n_in(bus_cd_n_in), .bus_io_n_in(bus_io_n_in),
    .bus_atn_n_in(bus_atn_n_in), .bus_rst_n_in(bus_rst_n_in), .arb_data_out(arb_data_out),
    .arb_data_oe_out(arb_data_oe_out), .seq_connected_in(seq_connected_in),
    .seq_initiator_in(seq_initiator_in), .seq_arbitrating_in(seq_arbitrating_in),
    .seq_cmd_done_in(seq_cmd_done_in), .seq_cmd_int_req_in(seq_cmd_int_req_in),
    .seq_abnormal_in(seq_abnormal_in), .seq_orderly_point_in(seq_orderly_point_in),
    .seq_selected_in(seq_selected_in), .sel_response_en_in(sel_response_en_in),
    .async_write_start_in(async_write_start_in), .fifo_half_access_in(fifo_half_access_in),
    .parity_error_in(parity_error_in), .overrun_in(overrun_in),
    .force_connect_out(force_connect_out), .skip_arbitration_out(skip_arbitration_out),
    .soft_abort_pending_out(soft_abort_pending_out), .pipeline_clear_out(pipeline_clear_out),
    .sequencer_halt_out(sequencer_halt_out), .sm_error_set_out(sm_error_set_out),
    .cmd_complete_event_out(cmd_complete_event_out),
    .write_setup_hold_out(write_setup_hold_out)
  );

  initial
  begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  // ----
  // Shared tasks
  // ----
  task chk(input string nm, input [7:0] e, input [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task wr(input [4:0] a, input [7:0] d);
    @(posedge ref_clk_in);
    {cpu_addr_in, cpu_wdata_in, cpu_wr_in} <= {a, d, 1'b1};
    @(posedge ref_clk_in);
    cpu_wr_in <= 1'b0;
  endtask
  task rd(input [4:0] a);
    @(posedge ref_clk_in);
    {cpu_addr_in, cpu_rd_in} <= {a, 1'b1};
    @(posedge ref_clk_in);
    cpu_rd_in <= 1'b0;
    #1 q = cpu_rdata_out;
  endtask
  task results;
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----
  // Scenarios
  // ----
  task t_pins;
    logic [7:0] q1;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge ref_clk_in);
      lines <= k ? 9'h02A : 9'h055;
      seq_connected_in <= k[0];
      repeat (3) @(posedge ref_clk_in);
      rd(5'h04);
      q1 = q;
      rd(5'h04);
      chk("status twice", q1, q);
      chk("status", {k[0], k ? 7'h2A : 7'h55}, q);
    end
    @(posedge ref_clk_in);
    seq_connected_in <= 1'b0;
    wr(5'h04, 8'h80);
    rd(5'h04);
    chk("forced", 8'hAA, q);
    chk("force out", 8'h01, {7'h0, force_connect_out});
    wr(5'h04, 8'h00);
    $display("pins test done");
  endtask
  task t_hard;
    wr(5'h05, 8'h03);
    wr(5'h04, 8'h40);
    #1 chk("hard pulses", 8'h0F, {4'h0, pipeline_clear_out, sequencer_halt_out,
      sm_error_set_out, cmd_complete_event_out});
    chk("irq", 8'h01, {7'h0, cpu_irq_out});
    rd(5'h05);
    chk("hard status", 8'h03, q);
    rd(5'h05);
    chk("cleared", 8'h00, q);
    chk("irq off", 8'h00, {7'h0, cpu_irq_out});
    $display("hard abort test done");
  endtask
  task t_soft;
    wr(5'h04, 8'h20);
    repeat (3) @(posedge ref_clk_in);
    #1 chk("pending", 8'h01, {7'h0, soft_abort_pending_out});
    @(posedge ref_clk_in);
    seq_orderly_point_in <= 1'b1;
    @(posedge ref_clk_in);
    seq_orderly_point_in <= 1'b0;
    #1 chk("soft pulses", 8'h0B, {soft_abort_pending_out, pipeline_clear_out,
      sequencer_halt_out, sm_error_set_out, cmd_complete_event_out});
    rd(5'h05);
    chk("soft status", 8'h03, q);
    $display("soft abort test done");
  endtask
  task t_events;
    logic [7:0] e;
    for (int k = 0; k < 8; k++)
    begin
      e = k == 0 ? 8'h01 : k == 2 ? 8'h03 : k == 3 || k == 4 ? 8'h04 :
        k == 5 ? 8'h08 : k == 6 ? 8'h40 : k == 7 ? 8'h10 : 8'h00;
      @(posedge ref_clk_in);
      {seq_initiator_in, seq_connected_in} <= {2{k == 7}};
      wr(5'h05, e | 8'h01);
      @(posedge ref_clk_in);
      case (k)
        0: {seq_cmd_done_in, seq_cmd_int_req_in} <= 2'b11;
        1: seq_cmd_done_in <= 1'b1;
        2: seq_abnormal_in <= 1'b1;
        3: parity_error_in <= 1'b1;
        4: overrun_in <= 1'b1;
        5: fifo_half_access_in <= 1'b1;
        6: lines <= 9'h100;
        default: lines <= 9'h004;
      endcase
      @(posedge ref_clk_in);
      {seq_cmd_done_in, seq_cmd_int_req_in, seq_abnormal_in} <= 3'h0;
      {parity_error_in, overrun_in, fifo_half_access_in} <= 3'h0;
      if (k == 6)
        lines <= 9'h000;
      #1 chk("abort clear", {7'h0, k == 2}, {7'h0, pipeline_clear_out});
      repeat (3) @(posedge ref_clk_in);
      #1 chk("event irq", {7'h0, |e}, {7'h0, cpu_irq_out});
      wr(5'h05, ~e);
      #1 chk("masked irq", 8'h00, {7'h0, cpu_irq_out});
      rd(5'h05);
      chk("event", e, q);
      @(posedge ref_clk_in);
      seq_initiator_in <= 1'b0;
      @(posedge ref_clk_in);
      lines <= 9'h000;
    end
    $display("event test done");
  endtask
  task t_live;
    @(posedge ref_clk_in);
    {seq_selected_in, sel_response_en_in, seq_connected_in, lines} <= {3'b110, 9'h080};
    repeat (3) @(posedge ref_clk_in);
    rd(5'h05);
    chk("live select", 8'h20, q);
    @(posedge ref_clk_in);
    {sel_response_en_in, seq_connected_in} <= 2'b01;
    for (int k = 0; k < 2; k++)
    begin
      rd(5'h05);
      chk("live attention", 8'h80, q);
    end
    @(posedge ref_clk_in);
    {seq_selected_in, seq_connected_in, lines} <= 11'h000;
    $display("live test done");
  endtask
  task t_survive;
    @(posedge ref_clk_in);
    parity_error_in <= 1'b1;
    @(posedge ref_clk_in);
    {parity_error_in, cpu_addr_in, cpu_rd_in} <= {1'b0, 5'h05, 1'b1};
    @(posedge ref_clk_in);
    @(posedge ref_clk_in);
    fifo_half_access_in <= 1'b1;
    @(posedge ref_clk_in);
    {fifo_half_access_in, cpu_rd_in} <= 2'b00;
    #1 chk("snapshot", 8'h04, cpu_rdata_out);
    rd(5'h05);
    chk("survivor", 8'h08, q);
    $display("survive test done");
  endtask
  task t_arb;
    for (int i = 0; i < 8; i++)
    begin
      wr(5'h04, 8'h18 | i[7:0]);
      seq_arbitrating_in <= 1'b1;
      #1 chk("arb enable", 8'h01 << i, arb_data_oe_out);
      chk("skip", 8'h01, {7'h0, skip_arbitration_out});
      @(posedge ref_clk_in);
      {seq_arbitrating_in, async_write_start_in} <= 2'b01;
      @(posedge ref_clk_in);
      async_write_start_in <= 1'b0;
      #1 chk("setup hold", 8'h01, {7'h0, write_setup_hold_out});
      @(posedge ref_clk_in);
      #1 chk("setup hold 2", 8'h01, {7'h0, write_setup_hold_out});
    end
    wr(5'h04, 8'h00);
    #1 chk("arb idle", 8'h00, arb_data_oe_out);
    chk("arb data", 8'h00, arb_data_out);
    $display("arbitration test done");
  endtask

  always @(posedge ref_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      err_count++;
      results;
    end
  end

  initial
  begin
    {cpu_wr_in, cpu_rd_in, seq_connected_in, seq_initiator_in, seq_arbitrating_in} = 5'h00;
    {seq_cmd_done_in, seq_cmd_int_req_in, seq_abnormal_in, seq_orderly_point_in} = 4'h0;
    {seq_selected_in, sel_response_en_in, async_write_start_in} = 3'h0;
    {fifo_half_access_in, parity_error_in, overrun_in} = 3'h0;
    {cpu_addr_in, cpu_wdata_in, lines, rst_in} = {5'h00, 8'h00, 9'h000, 1'b1};
    {err_count, samples_checked, cycles} = {32'd0, 32'd0, 32'd0};
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd(5'h05);
    chk("reset status", 8'h00, q);
    t_pins;
    t_hard;
    t_soft;
    t_events;
    t_live;
    t_survive;
    t_arb;
    results;
  end
endmodule // tb_scb_regs

bind scb_regs scb_regs_assertions chk_u (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .cpu_addr_in(cpu_addr_in),
  .cpu_wdata_in(cpu_wdata_in), .cpu_wr_in(cpu_wr_in), .cpu_rd_in(cpu_rd_in),
  .cpu_rdata_out(cpu_rdata_out), .cpu_irq_out(cpu_irq_out), .arb_data_out(arb_data_out),
  .arb_data_oe_out(arb_data_oe_out), .seq_connected_in(seq_connected_in),
  .seq_arbitrating_in(seq_arbitrating_in), .seq_orderly_point_in(seq_orderly_point_in),
  .async_write_start_in(async_write_start_in), .force_connect_out(force_connect_out),
  .skip_arbitration_out(skip_arbitration_out),
  .soft_abort_pending_out(soft_abort_pending_out), .pipeline_clear_out(pipeline_clear_out),
  .sequencer_halt_out(sequencer_halt_out), .sm_error_set_out(sm_error_set_out),
  .cmd_complete_event_out(cmd_complete_event_out),
  .write_setup_hold_out(write_setup_hold_out)
);

// file: verilog/scb_map.vh
// Register offsets, field positions, reset values and timing counts for
// the bus configuration/status and interrupt register pair.
// Assumes inclusion by bare name from the design files of this block.
`ifndef SCB_MAP_VH
`define SCB_MAP_VH

// ----------------------------------------------------------------------
// Register offsets on the local processor port
// ----------------------------------------------------------------------
`define SCB_ADDR_W 5
`define SCB_ADDR_CFG 5'h04
`define SCB_ADDR_INT 5'h05

// ----------------------------------------------------------------------
// Configuration write fields
// ----------------------------------------------------------------------
`define SCB_CFG_FORCE 7
`define SCB_CFG_HARD 6
`define SCB_CFG_SOFT 5
`define SCB_CFG_SKIP_ARB 4
`define SCB_CFG_SETUP 3
`define SCB_CFG_ID_HI 2
`define SCB_CFG_ID_LO 0

// ----------------------------------------------------------------------
// Status read fields
// ----------------------------------------------------------------------
`define SCB_ST_CONN 7
`define SCB_ST_SEL 6
`define SCB_ST_BSY 5
`define SCB_ST_ACK 4
`define SCB_ST_REQ 3
`define SCB_ST_MSG 2
`define SCB_ST_CD 1
`define SCB_ST_IO 0

// ----------------------------------------------------------------------
// Interrupt mask / status fields
// ----------------------------------------------------------------------
`define SCB_IRQ_DONE 0
`define SCB_IRQ_EXT 1
`define SCB_IRQ_PAR 2
`define SCB_IRQ_HALF 3
`define SCB_IRQ_PHASE 4
`define SCB_IRQ_SEL 5
`define SCB_IRQ_RST 6
`define SCB_IRQ_ATN 7
// Bits held in latches; the others pass live to the mask gate
`define SCB_IRQ_LATCHED 8'h5F

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define SCB_BYTE_ZERO 8'h00
`define SCB_ID_ONE 8'h01
`define SCB_SETUP_CLKS 2'h2
`define SCB_CNT_ZERO 2'h0
`define SCB_CNT_ONE 2'h1
`define SCB_SYNC_W 9

// ----------------------------------------------------------------------
// Synchronised pin positions
// ----------------------------------------------------------------------
`define SCB_PIN_RST 8
`define SCB_PIN_ATN 7
`define SCB_PIN_SEL 6
`define SCB_PIN_BSY 5
`define SCB_PIN_ACK 4
`define SCB_PIN_REQ 3
`define SCB_PIN_MSG 2
`define SCB_PIN_CD 1
`define SCB_PIN_IO 0

`endif

// file: verilog/scb_regs.v
// Bus configuration/status and interrupt mask/status register pair of a
// bus interface controller, on the local processor register port.
// Assumes the pipeline sequencer, FIFO and transfer logic sit alongside on
// the same clock; the bus control lines arrive as asynchronous pins.
`timescale 1ns/10ps
`include "scb_map.vh"

module scb_regs (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_in,
  // Local processor register port
  input wire [4:0] cpu_addr_in,
  input wire [7:0] cpu_wdata_in,
  input wire cpu_wr_in,
  input wire cpu_rd_in,
  output reg [7:0] cpu_rdata_out,
  output wire cpu_irq_out,
  // Bus control pins, active low
  input wire bus_sel_n_in,
  input wire bus_bsy_n_in,
  input wire bus_ack_n_in,
  input wire bus_req_n_in,
  input wire bus_msg_n_in,
  input wire bus_cd_n_in,
  input wire bus_io_n_in,
  input wire bus_atn_n_in,
  input wire bus_rst_n_in,
  // Arbitration identifier on the data lines, open drain
  output wire [7:0] arb_data_out,
  output wire [7:0] arb_data_oe_out,
  // Sequencer status
  input wire seq_connected_in,
  input wire seq_initiator_in,
  input wire seq_arbitrating_in,
  input wire seq_cmd_done_in,
  input wire seq_cmd_int_req_in,
  input wire seq_abnormal_in,
  input wire seq_orderly_point_in,
  input wire seq_selected_in,
  input wire sel_response_en_in,
  input wire async_write_start_in,
  // FIFO and data path events
  input wire fifo_half_access_in,
  input wire parity_error_in,
  input wire overrun_in,
  // Sequencer control
  output wire force_connect_out,
  output wire skip_arbitration_out,
  output wire soft_abort_pending_out,
  output reg pipeline_clear_out,
  output reg sequencer_halt_out,
  output reg sm_error_set_out,
  output reg cmd_complete_event_out,
  output wire write_setup_hold_out
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  reg force_connect;
  reg soft_abort;
  reg skip_arbitration;
  reg extra_setup;
  reg [2:0] own_id;
  reg [7:0] irq_mask;
  reg [7:0] irq_latch;
  reg [7:0] read_snapshot;
  reg cpu_rd_prev;
  reg [2:0] phase_prev;
  reg phase_valid;
  reg [1:0] setup_count;
  reg [7:0] next_irq_latch;
  reg [7:0] irq_set;
  wire [`SCB_SYNC_W-1:0] pins_async;
  wire [`SCB_SYNC_W-1:0] pins_sync;
  wire live_sel;
  wire live_bsy;
  wire live_ack;
  wire live_req;
  wire live_msg;
  wire live_cd;
  wire live_io;
  wire live_atn;
  wire live_rst;
  wire connected;
  wire [2:0] phase_now;
  wire [7:0] status_view;
  wire [7:0] irq_view;
  wire cfg_write;
  wire mask_write;
  wire hard_abort;
  wire soft_done;
  wire rd_start;
  wire rd_end;
  wire int_read;

  // --------------------------------------------------------------------
  // Pin synchronisers (active-low pins turned to asserted levels)
  // --------------------------------------------------------------------
  // Nine pins, each reading one when another device pulls its line low
  assign pins_async = ~{bus_rst_n_in, bus_atn_n_in, bus_sel_n_in, bus_bsy_n_in,
                        bus_ack_n_in, bus_req_n_in, bus_msg_n_in, bus_cd_n_in,
                        bus_io_n_in};

  scb_sync #(
    .W(`SCB_SYNC_W)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .async_in(pins_async),
    .sync_out(pins_sync)
  );

  assign live_rst = pins_sync[`SCB_PIN_RST];
  assign live_atn = pins_sync[`SCB_PIN_ATN];
  assign live_sel = pins_sync[`SCB_PIN_SEL];
  assign live_bsy = pins_sync[`SCB_PIN_BSY];
  assign live_ack = pins_sync[`SCB_PIN_ACK];
  assign live_req = pins_sync[`SCB_PIN_REQ];
  assign live_msg = pins_sync[`SCB_PIN_MSG];
  assign live_cd = pins_sync[`SCB_PIN_CD];
  assign live_io = pins_sync[`SCB_PIN_IO];
  assign phase_now = {live_msg, live_cd, live_io};

  // --------------------------------------------------------------------
  // Register port decode
  // --------------------------------------------------------------------
  // The processor port is taken as synchronous to the system clock
  assign cfg_write = cpu_wr_in && (cpu_addr_in == `SCB_ADDR_CFG);
  assign mask_write = cpu_wr_in && (cpu_addr_in == `SCB_ADDR_INT);
  assign int_read = cpu_rd_in && (cpu_addr_in == `SCB_ADDR_INT);
  assign rd_start = int_read && !cpu_rd_prev;
  // Trailing edge: strobe dropped after an interrupt status read
  assign rd_end = !cpu_rd_in && cpu_rd_prev;

  // Hard abort is a write-time pulse; the bit itself is never stored
  assign hard_abort = cfg_write && cpu_wdata_in[`SCB_CFG_HARD];
  assign soft_done = soft_abort && seq_orderly_point_in && !hard_abort;

  // --------------------------------------------------------------------
  // Configuration register
  // --------------------------------------------------------------------
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      force_connect <= 1'b0;
      soft_abort <= 1'b0;
      skip_arbitration <= 1'b0;
      extra_setup <= 1'b0;
      own_id <= 3'h0;
    end
    else
    begin
      if (cfg_write)
      begin
        force_connect <= cpu_wdata_in[`SCB_CFG_FORCE];
        skip_arbitration <= cpu_wdata_in[`SCB_CFG_SKIP_ARB];
        extra_setup <= cpu_wdata_in[`SCB_CFG_SETUP];
        own_id <= cpu_wdata_in[`SCB_CFG_ID_HI:`SCB_CFG_ID_LO];
      end
      // Hard abort supersedes any soft abort still waiting
      if (hard_abort)
        soft_abort <= 1'b0;
      else if (cfg_write && cpu_wdata_in[`SCB_CFG_SOFT])
        soft_abort <= 1'b1;
      else if (soft_done)
        soft_abort <= 1'b0;
    end
  end

  assign force_connect_out = force_connect;
  assign skip_arbitration_out = skip_arbitration;
  // Lets the sequencer look for its next orderly stopping point
  assign soft_abort_pending_out = soft_abort;
  assign connected = seq_connected_in || force_connect;

  // --------------------------------------------------------------------
  // Abort pulses to the sequencer
  // --------------------------------------------------------------------
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      pipeline_clear_out <= 1'b0;
      sequencer_halt_out <= 1'b0;
      sm_error_set_out <= 1'b0;
      cmd_complete_event_out <= 1'b0;
    end
    else
    begin
      // Abnormal termination empties the queue just as an abort does
      pipeline_clear_out <= hard_abort || soft_done || seq_abnormal_in;
      sequencer_halt_out <= hard_abort;
      sm_error_set_out <= hard_abort || soft_done;
      cmd_complete_event_out <= hard_abort || soft_done;
    end
  end

  // --------------------------------------------------------------------
  // Arbitration identifier, decoded to one line
  // --------------------------------------------------------------------
  // Open drain: a line is pulled only where the decoded bit is one
  // Data value never leaves zero, so no line is ever driven high
  assign arb_data_out = `SCB_BYTE_ZERO;
  assign arb_data_oe_out = seq_arbitrating_in ? (`SCB_ID_ONE << own_id) : `SCB_BYTE_ZERO;

  // --------------------------------------------------------------------
  // Extra data setup for asynchronous writes
  // --------------------------------------------------------------------
  // Synchronous transfers never raise the start strobe, so they are untouched
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
      setup_count <= `SCB_CNT_ZERO;
    else if (async_write_start_in && extra_setup)
      // A new start reloads the count, so each write gets the full setup
      setup_count <= `SCB_SETUP_CLKS;
    else if (setup_count != `SCB_CNT_ZERO)
      setup_count <= setup_count - `SCB_CNT_ONE;
  end

  assign write_setup_hold_out = (setup_count != `SCB_CNT_ZERO);

  // --------------------------------------------------------------------
  // Phase change tracking in initiator role
  // --------------------------------------------------------------------
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      phase_prev <= 3'h0;
      phase_valid <= 1'b0;
    end
    else
    begin
      // Tracked in every role, so the first compare as initiator is sound
      phase_prev <= phase_now;
      phase_valid <= seq_initiator_in && connected;
    end
  end

  // --------------------------------------------------------------------
  // Interrupt events and latches
  // --------------------------------------------------------------------
  always @*
  begin
    irq_set = `SCB_BYTE_ZERO;
    irq_set[`SCB_IRQ_DONE] = (seq_cmd_done_in && seq_cmd_int_req_in)
                             || seq_abnormal_in || hard_abort || soft_done;
    irq_set[`SCB_IRQ_EXT] = seq_abnormal_in || hard_abort || soft_done;
    irq_set[`SCB_IRQ_PAR] = parity_error_in || overrun_in;
    irq_set[`SCB_IRQ_HALF] = fifo_half_access_in;
    irq_set[`SCB_IRQ_PHASE] = phase_valid && seq_initiator_in
                              && (phase_now != phase_prev);
    irq_set[`SCB_IRQ_RST] = live_rst;
    next_irq_latch = irq_latch;
    // Clear first, then set, so an event in the clearing cycle survives
    if (rd_end)
      next_irq_latch = next_irq_latch & ~read_snapshot;
    next_irq_latch = (next_irq_latch | irq_set) & `SCB_IRQ_LATCHED;
  end

  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      irq_latch <= `SCB_BYTE_ZERO;
      irq_mask <= `SCB_BYTE_ZERO;
      read_snapshot <= `SCB_BYTE_ZERO;
      cpu_rd_prev <= 1'b0;
    end
    else
    begin
      irq_latch <= next_irq_latch;
      cpu_rd_prev <= int_read;
      if (mask_write)
        irq_mask <= cpu_wdata_in;
      // Only bits already set when the strobe began may be cleared by it
      if (rd_start)
        read_snapshot <= irq_latch;
      else if (rd_end)
        read_snapshot <= `SCB_BYTE_ZERO;
    end
  end

  // Live bits bypass the latches and reach the mask gate directly
  assign irq_view = irq_latch
                    | ({7'h00, live_atn && connected} << `SCB_IRQ_ATN)
                    | ({7'h00, seq_selected_in && sel_response_en_in} << `SCB_IRQ_SEL);

  // Level output; latched causes drop only when software clears or masks them, live ones when their source drops
  assign cpu_irq_out = |(irq_view & irq_mask);

  // --------------------------------------------------------------------
  // Status read view
  // --------------------------------------------------------------------
  // Unlatched bits may move between reads; software compares two samples
  assign status_view = {connected, live_sel, live_bsy, live_ack, live_req,
                        live_msg, live_cd, live_io};

  always @(posedge ref_clk_in)
  begin
    if (rst_in)
      cpu_rdata_out <= `SCB_BYTE_ZERO;
    else if (cpu_rd_in)
    begin
      case (cpu_addr_in)
        `SCB_ADDR_CFG: cpu_rdata_out <= status_view;
        `SCB_ADDR_INT: cpu_rdata_out <= irq_view;
        // Unused offsets read zero rather than stale data
        default: cpu_rdata_out <= `SCB_BYTE_ZERO;
      endcase
    end
  end

endmodule // scb_regs

// file: verilog/scb_sync.v
// Two-flop synchroniser bank for the bus control lines.
// Assumes one clock and a synchronous, active-high reset.
`timescale 1ns/10ps

module scb_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_in,
  // Asynchronous levels and their synchronised copies
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  genvar i;

  // --------------------------------------------------------------------
  // Per-bit flop pair; the first flop feeds only the second
  // --------------------------------------------------------------------
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      reg meta;
      reg stable;
      always @(posedge ref_clk_in)
      begin
        if (rst_in)
        begin
          meta <= 1'b0;
          stable <= 1'b0;
        end
        else
        begin
          meta <= async_in[i];
          stable <= meta;
        end
      end
      assign sync_out[i] = stable;
    end
  endgenerate

endmodule // scb_sync
